// ==== design/blr_regs_top.sv ====
// Current, ramp-time and fault-flag registers of the backlight driver
`timescale 1ns/1ps
`default_nettype none
module blr_regs_top import blr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR  = BLR_I2C_ADDR,
  parameter int         CODE_W    = 9,
  parameter longint     START0_CYC = BLR_START0_CYC,
  parameter longint     ZERO_CYC   = BLR_ZERO_CYC,
  parameter longint     STEP1_CYC  = BLR_STEP1_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              sclPin,
  input  wire logic              sdaPinIn,
  output logic                   sdaPinOut,
  output logic                   sdaPinOe,
  input  wire logic              overcurrentFlag,
  input  wire logic              overvoltageFlag,
  input  wire logic              thermalTripFlag,
  input  wire logic              sleepStatus,
  input  wire logic [2:0]        irqSourceEnable,
  input  wire logic              irqGlobalEnable,
  input  wire logic [CODE_W-1:0] pwmEquivCode,
  input  wire logic              pwmEquivValid,
  output logic      [CODE_W-1:0] pwmSampledCode,
  output logic      [4:0]        bankAFullScale,
  output logic      [4:0]        bankBFullScale,
  output logic      [31:0]       startRampCycles,
  output logic      [31:0]       shutRampCycles,
  output logic      [31:0]       upRampCycles,
  output logic      [31:0]       downRampCycles,
  output logic                   faultIrqPinNOut,
  output logic                   faultIrqPinNOe
);

  // Reset release path
  logic       rstMeta;
  logic       rstN;

  // Register bank
  logic [7:0] bankACur_reg;
  logic [7:0] bankBCur_reg;
  logic [7:0] ssRamp_reg;
  logic [7:0] dimRamp_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;

  // Serial port side
  logic [7:0] regPtr;
  logic       wrStrobe;
  logic [7:0] wrData;
  logic       rdStrobe;
  logic [7:0] rdData;
  logic       i2cSdaOut;
  logic       i2cSdaOe;

  // Fault path
  logic [2:0] faultRaw;
  logic [2:0] faultMeta;
  logic [2:0] faultSync;
  logic [2:0] faultPrev;
  logic [2:0] faultEnabled;
  logic [2:0] flagSet;
  logic       readClear;
  logic       clearedPrev;

  // Sampler output
  logic [CODE_W-1:0] sampledCode;

  // Time ladder: code 0 has its own length, others double from the step
  function automatic logic [31:0] rampLen(
    input logic [2:0] code,
    input longint     zeroLen
  );
    logic [31:0] step;
    step = 32'(STEP1_CYC);
    if (code == 3'h0) rampLen = 32'(zeroLen);
    else rampLen = step << (code - 3'h1);
  endfunction : rampLen

  // Reset is asserted at once and released through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Serial port slave
  blr_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk      (core_clk),
    .rstN     (rstN),
    .sclIn    (sclPin),
    .sdaIn    (sdaPinIn),
    .sdaOut   (i2cSdaOut),
    .sdaOe    (i2cSdaOe),
    .regPtr   (regPtr),
    .wrStrobe (wrStrobe),
    .wrData   (wrData),
    .rdStrobe (rdStrobe),
    .rdData   (rdData)
  );

  // Data pin drive, re-timed so the top outputs come from flops
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      sdaPinOut <= 1'b0;
      sdaPinOe  <= 1'b0;
    end else begin
      sdaPinOut <= i2cSdaOut;
      sdaPinOe  <= i2cSdaOe;
    end
  end

  // Host writes; unwritable bits are masked so they read as zero
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bankACur_reg <= BLR_RST_CUR;
      bankBCur_reg <= BLR_RST_CUR;
      ssRamp_reg   <= BLR_RST_RAMP;
      dimRamp_reg  <= BLR_RST_RAMP;
    end else if (wrStrobe) begin
      unique case (regPtr)
        BLR_OFS_CUR_A:    bankACur_reg <= wrData & BLR_MASK_CUR_A;
        BLR_OFS_CUR_B:    bankBCur_reg <= wrData & BLR_MASK_CUR_B;
        BLR_OFS_RAMP_SS:  ssRamp_reg   <= wrData & BLR_MASK_RAMP;
        BLR_OFS_RAMP_DIM: dimRamp_reg  <= wrData & BLR_MASK_RAMP;
        default: ; // Flags and unmapped offsets ignore writes
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    unique case (regPtr)
      BLR_OFS_CUR_A:    rdData = bankACur_reg;
      BLR_OFS_CUR_B:    rdData = bankBCur_reg;
      BLR_OFS_RAMP_SS:  rdData = ssRamp_reg;
      BLR_OFS_RAMP_DIM: rdData = dimRamp_reg;
      BLR_OFS_FLAGS:    rdData = {5'h00, flags_reg};
      default:          rdData = 8'h00;
    endcase
  end

  // Fault comparators are asynchronous to the core clock
  assign faultRaw = {overcurrentFlag, overvoltageFlag, thermalTripFlag};

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      faultMeta <= 3'h0;
      faultSync <= 3'h0;
      faultPrev <= 3'h0;
    end else begin
      faultMeta <= faultRaw;
      faultSync <= faultMeta;
      faultPrev <= faultSync;
    end
  end

  // A source counts only when its own and the global enable are set
  assign faultEnabled = irqSourceEnable & {3{irqGlobalEnable}};

  // Set on a new fault, or again right after a clearing read
  assign flagSet = faultSync & faultEnabled
                 & (~faultPrev | {3{clearedPrev}});

  // Reading the flags clears them, except while asleep
  assign readClear = rdStrobe && (regPtr == BLR_OFS_FLAGS)
                   && !sleepStatus;

  // A set in the clearing cycle wins, so no event is lost
  assign flags_next = (flags_reg & ~{3{readClear}}) | flagSet;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      flags_reg   <= BLR_RST_FLAGS;
      clearedPrev <= 1'b0;
    end else begin
      flags_reg   <= flags_next;
      clearedPrev <= readClear;
    end
  end

  // The clear leaves one released cycle before a re-set pulls the pin
  // again, which the host sees as a fresh event
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      faultIrqPinNOut <= 1'b0;
      faultIrqPinNOe  <= 1'b0;
    end else begin
      faultIrqPinNOut <= 1'b0; // Open drain: low or released
      faultIrqPinNOe  <= |(flags_reg & faultEnabled);
    end
  end

  // PWM equivalent-code filter, steered by the bank A register
  blr_pwm_sampler #(
    .CW (CODE_W)
  ) u_sampler (
    .clk        (core_clk),
    .rstN       (rstN),
    .codeValid  (pwmEquivValid),
    .codeIn     (pwmEquivCode),
    .hystFast   (bankACur_reg[BLR_BIT_HYST]),
    .lowerBound (bankACur_reg[BLR_BIT_LOWB]),
    .codeOut    (sampledCode)
  );

  // Current fields and sampled code to the analog side
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bankAFullScale <= BLR_RST_CUR[4:0];
      bankBFullScale <= BLR_RST_CUR[4:0];
      pwmSampledCode <= '0;
    end else begin
      bankAFullScale <= bankACur_reg[4:0];
      bankBFullScale <= bankBCur_reg[4:0];
      pwmSampledCode <= sampledCode;
    end
  end

  // Ramp lengths in core cycles; registered so the timers see clean values
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      startRampCycles <= 32'h0000_0000;
      shutRampCycles  <= 32'h0000_0000;
      upRampCycles    <= 32'h0000_0000;
      downRampCycles  <= 32'h0000_0000;
    end else begin
      startRampCycles <= rampLen(ssRamp_reg[5:3], START0_CYC);
      shutRampCycles  <= rampLen(ssRamp_reg[2:0], ZERO_CYC);
      upRampCycles    <= rampLen(dimRamp_reg[5:3], ZERO_CYC);
      downRampCycles  <= rampLen(dimRamp_reg[2:0], ZERO_CYC);
    end
  end

endmodule : blr_regs_top
`default_nettype wire

// ==== design/blr_pkg.sv ====
// Shared constants for the backlight current, ramp and fault register group
package blr_pkg;
  // Register offsets
  localparam logic [7:0] BLR_OFS_CUR_A = 8'h05;
  localparam logic [7:0] BLR_OFS_CUR_B = 8'h06;
  localparam logic [7:0] BLR_OFS_RAMP_SS = 8'h07;
  localparam logic [7:0] BLR_OFS_RAMP_DIM = 8'h08;
  localparam logic [7:0] BLR_OFS_FLAGS = 8'h09;
  // Values after reset
  localparam logic [7:0] BLR_RST_CUR = 8'h1F;
  localparam logic [7:0] BLR_RST_RAMP = 8'h00;
  localparam logic [2:0] BLR_RST_FLAGS = 3'h0;
  // Writable bits; everything else reads as zero
  localparam logic [7:0] BLR_MASK_CUR_A = 8'hDF;
  localparam logic [7:0] BLR_MASK_CUR_B = 8'h1F;
  localparam logic [7:0] BLR_MASK_RAMP = 8'h3F;
  // Field positions
  localparam int BLR_BIT_HYST = 7;
  localparam int BLR_BIT_LOWB = 6;
  localparam int BLR_HI_LSB = 3;
  localparam int BLR_FLAG_OC = 2;
  localparam int BLR_FLAG_OV = 1;
  localparam int BLR_FLAG_TT = 0;
  // Sampler hysteresis and lower bound
  localparam logic [1:0] BLR_HYST_SLOW = 2'h3;
  localparam logic [1:0] BLR_HYST_FAST = 2'h2;
  localparam int BLR_LB_FLOOR = 2;
  localparam int BLR_LB_CODE = 6;
  // Ramp timing at the 20 MHz core clock
  localparam longint BLR_CLK_HZ = 20000000;
  localparam longint BLR_T_START0_US = 4000;
  localparam longint BLR_T_ZERO_US = 500;
  localparam longint BLR_T_STEP1_US = 261000;
  localparam longint BLR_START0_CYC = BLR_T_START0_US * BLR_CLK_HZ / 1000000;
  localparam longint BLR_ZERO_CYC = BLR_T_ZERO_US * BLR_CLK_HZ / 1000000;
  localparam longint BLR_STEP1_CYC = BLR_T_STEP1_US * BLR_CLK_HZ / 1000000;
  // Serial port slave address; value is arbitrary
  localparam logic [6:0] BLR_I2C_ADDR = 7'h36;
endpackage : blr_pkg

// ==== design/blr_pwm_sampler.sv ====
// Hysteresis and lower-bound filter for the PWM equivalent code
`timescale 1ns/1ps
`default_nettype none
module blr_pwm_sampler import blr_pkg::*; #(
  parameter int CW = 9
) (
  input  wire logic          clk,
  input  wire logic          rstN,
  input  wire logic          codeValid,
  input  wire logic [CW-1:0] codeIn,
  input  wire logic          hystFast,
  input  wire logic          lowerBound,
  output logic      [CW-1:0] codeOut
);
  logic [CW-1:0] mapped;
  logic [CW-1:0] cand_reg;
  logic [1:0]    cnt_reg;
  logic [1:0]    need;

  // Without the lower bound, small codes snap to 0 or to the floor code
  always_comb begin
    mapped = codeIn;
    if (!lowerBound) begin
      if (codeIn < CW'(BLR_LB_FLOOR)) mapped = '0;
      else if (codeIn <= CW'(BLR_LB_CODE)) mapped = CW'(BLR_LB_CODE);
    end // else raw codes below the floor pass
    need = hystFast ? BLR_HYST_FAST : BLR_HYST_SLOW;
  end

  // Output moves only after enough consecutive equal new codes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      codeOut  <= '0;
      cand_reg <= '0;
      cnt_reg  <= 2'h0;
    end else if (codeValid) begin
      if (mapped == codeOut) begin
        cnt_reg <= 2'h0;
      end else if (mapped == cand_reg && cnt_reg != 2'h0) begin
        if (cnt_reg + 2'h1 >= need) begin
          codeOut <= mapped;
          cnt_reg <= 2'h0;
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end else begin
        cand_reg <= mapped;
        cnt_reg  <= 2'h1;
      end
    end
  end
endmodule : blr_pwm_sampler
`default_nettype wire

// ==== design/blr_i2c_slave.sv ====
// Serial-port slave: pointer byte, then auto-incrementing reads or writes
`timescale 1ns/1ps
`default_nettype none
module blr_i2c_slave import blr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = BLR_I2C_ADDR
) (
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      regPtr,
  output logic            wrStrobe,
  output logic [7:0]      wrData,
  output logic            rdStrobe,
  input  wire logic [7:0] rdData
);
  typedef enum logic [6:0] {
    BLR_IDLE = 7'h01, BLR_ADDR = 7'h02, BLR_AACK = 7'h04,
    BLR_WR   = 7'h08, BLR_WACK = 7'h10, BLR_RD   = 7'h20,
    BLR_RACK = 7'h40
  } blr_i2c_t;
  blr_i2c_t   st_reg;
  logic [1:0] sclSy, sdaSy;
  logic       sclD, sdaD, isRead, ptrDone, hostAck;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic       sclRise, sclFall, startC, stopC;

  // Pins are asynchronous: two stages, then a third for edge detection
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclSy <= 2'h3;
      sdaSy <= 2'h3;
      sclD  <= 1'b1;
      sdaD  <= 1'b1;
    end else begin
      sclSy <= {sclSy[0], sclIn};
      sdaSy <= {sdaSy[0], sdaIn};
      sclD  <= sclSy[1];
      sdaD  <= sdaSy[1];
    end
  end
  assign sclRise = sclSy[1] & ~sclD;
  assign sclFall = ~sclSy[1] & sclD;
  assign startC  = sclSy[1] & sdaD & ~sdaSy[1];
  assign stopC   = sclSy[1] & ~sdaD & sdaSy[1];
  assign sdaOut  = 1'b0; // Open drain: only ever pulls low

  // Protocol sequencer
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_reg <= BLR_IDLE;
      sdaOe <= 1'b0;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      regPtr <= 8'h00;
      isRead <= 1'b0;
      ptrDone <= 1'b0;
      hostAck <= 1'b0;
      wrStrobe <= 1'b0;
      wrData <= 8'h00;
      rdStrobe <= 1'b0;
    end else begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      if (startC) begin
        st_reg <= BLR_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopC) begin
        st_reg <= BLR_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        if (st_reg == BLR_ADDR || st_reg == BLR_WR) begin
          shift <= {shift[6:0], sdaSy[1]};
          bitCnt <= bitCnt + 4'h1;
        end else if (st_reg == BLR_RD) begin
          bitCnt <= bitCnt + 4'h1;
        end else if (st_reg == BLR_RACK) begin
          hostAck <= ~sdaSy[1];
          if (!sdaSy[1]) regPtr <= regPtr + 8'h01;
        end
      end else if (sclFall) begin
        unique case (st_reg)
          BLR_IDLE: ;
          BLR_ADDR: if (bitCnt == 4'h8) begin
            if (shift[7:1] == DEV_ADDR) begin
              sdaOe <= 1'b1;
              isRead <= shift[0];
              st_reg <= BLR_AACK;
            end else st_reg <= BLR_IDLE;
          end
          BLR_AACK: begin
            bitCnt <= 4'h0;
            ptrDone <= 1'b0;
            if (isRead) begin
              shift <= rdData;
              rdStrobe <= 1'b1;
              sdaOe <= ~rdData[7];
              st_reg <= BLR_RD;
            end else begin
              sdaOe <= 1'b0;
              st_reg <= BLR_WR;
            end
          end
          BLR_WR: if (bitCnt == 4'h8) begin
            sdaOe <= 1'b1;
            st_reg <= BLR_WACK;
            if (!ptrDone) regPtr <= shift;
            else begin
              wrData <= shift;
              wrStrobe <= 1'b1;
            end
          end
          BLR_WACK: begin
            sdaOe <= 1'b0;
            bitCnt <= 4'h0;
            if (ptrDone) regPtr <= regPtr + 8'h01;
            ptrDone <= 1'b1;
            st_reg <= BLR_WR;
          end
          BLR_RD: if (bitCnt == 4'h8) begin
            sdaOe <= 1'b0;
            st_reg <= BLR_RACK;
          end else begin
            shift <= {shift[6:0], 1'b0};
            sdaOe <= ~shift[6];
          end
          BLR_RACK: begin
            bitCnt <= 4'h0;
            if (hostAck) begin
              shift <= rdData;
              rdStrobe <= 1'b1;
              sdaOe <= ~rdData[7];
              st_reg <= BLR_RD;
            end else st_reg <= BLR_IDLE;
          end
        endcase
      end
    end
  end
endmodule : blr_i2c_slave
`default_nettype wire

// ==== verif/blr_regs_chk.sv ====
// Pin-level assertions for the current, ramp and fault register group
`timescale 1ns/1ps
`default_nettype none
module blr_regs_chk import blr_pkg::*; #(
  parameter int     CODE_W     = 9,
  parameter longint START0_CYC = BLR_START0_CYC,
  parameter longint ZERO_CYC   = BLR_ZERO_CYC,
  parameter longint STEP1_CYC  = BLR_STEP1_CYC
) (
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              overcurrentFlag,
  input wire logic              overvoltageFlag,
  input wire logic              thermalTripFlag,
  input wire logic [2:0]        irqSourceEnable,
  input wire logic              irqGlobalEnable,
  input wire logic              pwmEquivValid,
  input wire logic [CODE_W-1:0] pwmSampledCode,
  input wire logic [4:0]        bankAFullScale,
  input wire logic [4:0]        bankBFullScale,
  input wire logic [31:0]       startRampCycles,
  input wire logic [31:0]       shutRampCycles,
  input wire logic [31:0]       upRampCycles,
  input wire logic [31:0]       downRampCycles,
  input wire logic              faultIrqPinNOut,
  input wire logic              faultIrqPinNOe
);
  logic [3:0] faultAge;
  logic [3:0] rstAge;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // True when a ramp length is the code-0 value or a step of the ladder
  function automatic logic ladder(input logic [31:0] v, input longint z);
    ladder = (v == z);
    for (int k = 0; k < 7; k++) ladder |= (v == (STEP1_CYC << k));
  endfunction : ladder

  // Cycles since any fault input was high; saturates so it never wraps
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      faultAge <= 4'hF;
    end else if (overcurrentFlag | overvoltageFlag | thermalTripFlag) begin
      faultAge <= 4'h0;
    end else if (faultAge != 4'hF) begin
      faultAge <= faultAge + 4'h1;
    end
  end

  // Ramp outputs are zero while the synchronised reset drains out
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstAge <= 4'h0;
    end else if (rstAge != 4'hF) begin
      rstAge <= rstAge + 4'h1;
    end
  end

  a_fullscale_reset: assert property (
    $rose(reset_n) |-> bankAFullScale == 5'h1F && bankBFullScale == 5'h1F)
    else $error("full-scale fields not at reset value");
  a_ramp_after_reset: assert property (
    $rose(reset_n) |-> ##[2:6] (startRampCycles == START0_CYC
      && shutRampCycles == ZERO_CYC && upRampCycles == ZERO_CYC
      && downRampCycles == ZERO_CYC))
    else $error("ramp lengths wrong after reset");
  a_ramp_on_ladder: assert property (
    rstAge > 4'h6 |-> ladder(startRampCycles, START0_CYC)
      && ladder(shutRampCycles, ZERO_CYC) && ladder(upRampCycles, ZERO_CYC)
      && ladder(downRampCycles, ZERO_CYC))
    else $error("ramp length off the ladder");
  a_irq_global_gate: assert property (
    !irqGlobalEnable && !$past(irqGlobalEnable) |-> !faultIrqPinNOe)
    else $error("interrupt pin low with global enable off");
  a_irq_source_gate: assert property (
    irqSourceEnable == 3'h0 && $past(irqSourceEnable) == 3'h0
      |-> !faultIrqPinNOe)
    else $error("interrupt pin low with all sources off");
  a_irq_has_cause: assert property (
    $rose(faultIrqPinNOe)
      && $past(irqSourceEnable) == $past(irqSourceEnable, 2)
      && $past(irqGlobalEnable) == $past(irqGlobalEnable, 2)
      |-> faultAge < 4'h8)
    else $error("interrupt pin fell with no recent fault");
  a_irq_pin_level: assert property (
    faultIrqPinNOut == 1'b0)
    else $error("interrupt pin drives high");
  a_sampler_timing: assert property (
    $changed(pwmSampledCode) |-> $past(pwmEquivValid)
      || $past(pwmEquivValid, 2))
    else $error("sampler output moved without a sample");

  c_irq_clear: cover property ($fell(faultIrqPinNOe));
  c_pwm_move: cover property ($changed(pwmSampledCode));
  c_irq_all_on: cover property (faultIrqPinNOe && irqSourceEnable == 3'h7);
endmodule : blr_regs_chk

bind blr_regs_top blr_regs_chk #(
  .CODE_W(CODE_W), .START0_CYC(START0_CYC), .ZERO_CYC(ZERO_CYC),
  .STEP1_CYC(STEP1_CYC)
) u_blr_regs_chk (
  .core_clk(core_clk), .reset_n(reset_n),
  .overcurrentFlag(overcurrentFlag), .overvoltageFlag(overvoltageFlag),
  .thermalTripFlag(thermalTripFlag), .irqSourceEnable(irqSourceEnable),
  .irqGlobalEnable(irqGlobalEnable), .pwmEquivValid(pwmEquivValid),
  .pwmSampledCode(pwmSampledCode), .bankAFullScale(bankAFullScale),
  .bankBFullScale(bankBFullScale), .startRampCycles(startRampCycles),
  .shutRampCycles(shutRampCycles), .upRampCycles(upRampCycles),
  .downRampCycles(downRampCycles), .faultIrqPinNOut(faultIrqPinNOut),
  .faultIrqPinNOe(faultIrqPinNOe)
);
`default_nettype wire

// ==== verif/blr_i2c_host.sv ====
// Host processor model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module blr_i2c_host import blr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = BLR_I2C_ADDR,
  parameter int         HALF     = 12
) (
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaDrv
);
  // Both lines released; the clock stands still between frames
  initial begin
    sclOut = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic gap();
    repeat (HALF) @(negedge clk);
  endtask : gap

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sdaDrv = 1'b1;
    gap();
    sclOut = 1'b1;
    gap();
    sdaDrv = 1'b0;
    gap();
    sclOut = 1'b0;
    gap();
  endtask : start

  task automatic stop();
    sdaDrv = 1'b0;
    gap();
    sclOut = 1'b1;
    gap();
    sdaDrv = 1'b1;
    gap();
  endtask : stop

  // Eight bits MSB first plus the acknowledge slot; data moves mid-low
  // and is sampled late in the high phase, clear of the pin latency
  task automatic xbyte(input logic [7:0] d, input logic ackIn,
                       output logic [7:0] q, output logic ackOut);
    logic [8:0] o;
    logic [8:0] s;
    o = {d, ackIn};
    for (int i = 8; i >= 0; i--) begin
      sdaDrv = o[i];
      gap();
      sclOut = 1'b1;
      gap();
      s[i] = sdaLine;
      sclOut = 1'b0;
      gap();
    end
    q = s[8:1];
    ackOut = s[0];
  endtask : xbyte

  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic nak);
    logic [7:0] u;
    logic [2:0] a;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, u, a[2]);
    xbyte(p, 1'b1, u, a[1]);
    xbyte(d, 1'b1, u, a[0]);
    stop();
    nak = |a;
  endtask : wr

  // Single-byte read; the host's NACK ends the transfer
  task automatic rd(input logic [7:0] p, output logic [7:0] q,
                    output logic nak);
    logic [7:0] u;
    logic [2:0] a;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, u, a[2]);
    xbyte(p, 1'b1, u, a[1]);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b1, u, a[0]);
    xbyte(8'hFF, 1'b1, q, u[0]);
    stop();
    nak = |a;
  endtask : rd
endmodule : blr_i2c_host
`default_nettype wire

// ==== verif/blr_regs_top_test.sv ====
// Self-checking bench for the current, ramp and fault register group
`timescale 1ns/1ps
`default_nettype none
module blr_regs_top_test import blr_pkg::*; ;
  localparam int S0 = 8;
  localparam int Z0 = 2;
  localparam int ST = 16;
  logic        core_clk, reset_n, sclPin, hostSda, sdaLine;
  logic        sdaPinOut, sdaPinOe, sleepStatus, irqGlobalEnable;
  logic [2:0]  faults, irqSourceEnable;
  logic [8:0]  pwmEquivCode, pwmSampledCode;
  logic        pwmEquivValid, faultIrqPinNOut, faultIrqPinNOe;
  logic [4:0]  bankAFullScale, bankBFullScale;
  logic [31:0] startRampCycles, shutRampCycles, upRampCycles, downRampCycles;
  int          badCount;
  int          checked;

  // Open-drain data line with pull-up
  assign sdaLine = hostSda & ~(sdaPinOe & ~sdaPinOut);

  blr_regs_top #(.START0_CYC(S0), .ZERO_CYC(Z0), .STEP1_CYC(ST))
    u_blr_regs_top (
    .core_clk(core_clk), .reset_n(reset_n), .sclPin(sclPin),
    .sdaPinIn(sdaLine), .sdaPinOut(sdaPinOut), .sdaPinOe(sdaPinOe),
    .overcurrentFlag(faults[2]), .overvoltageFlag(faults[1]),
    .thermalTripFlag(faults[0]), .sleepStatus(sleepStatus),
    .irqSourceEnable(irqSourceEnable), .irqGlobalEnable(irqGlobalEnable),
    .pwmEquivCode(pwmEquivCode), .pwmEquivValid(pwmEquivValid),
    .pwmSampledCode(pwmSampledCode), .bankAFullScale(bankAFullScale),
    .bankBFullScale(bankBFullScale), .startRampCycles(startRampCycles),
    .shutRampCycles(shutRampCycles), .upRampCycles(upRampCycles),
    .downRampCycles(downRampCycles), .faultIrqPinNOut(faultIrqPinNOut),
    .faultIrqPinNOe(faultIrqPinNOe));

  blr_i2c_host u_blr_i2c_host (
    .clk(core_clk), .sdaLine(sdaLine), .sclOut(sclPin), .sdaDrv(hostSda));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finishTest();
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finishTest

  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic nak;
    u_blr_i2c_host.wr(p, d, nak);
    chk("wr ack", 32'(nak), 32'h0);
  endtask : wreg

  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic       nak;
    u_blr_i2c_host.rd(p, q, nak);
    chk("rd ack", 32'(nak), 32'h0);
    chk("rd data", 32'(q), 32'(e));
  endtask : rchk

  // Fault held long enough to cross the input synchroniser
  task automatic pulse(input logic [2:0] f);
    faults = f;
    repeat (10) @(negedge core_clk);
    faults = 3'h0;
    repeat (4) @(negedge core_clk);
  endtask : pulse

  task automatic pwm(input logic [8:0] c, input int n, input logic [8:0] e);
    repeat (n) begin
      pwmEquivCode = c;
      pwmEquivValid = 1'b1;
      @(negedge core_clk);
      pwmEquivValid = 1'b0;
      @(negedge core_clk);
    end
    repeat (2) @(negedge core_clk);
    chk("pwm", 32'(pwmSampledCode), 32'(e));
  endtask : pwm

  function automatic logic [31:0] rampExp(input int c, input int z);
    rampExp = (c == 0) ? 32'(z) : 32'(ST) << (c - 1);
  endfunction : rampExp

  // Main sequence
  initial begin
    {reset_n, sleepStatus, irqGlobalEnable, pwmEquivValid} = 4'h2;
    faults = 3'h0;
    irqSourceEnable = 3'h7;
    pwmEquivCode = 9'h000;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("bankA", 32'(bankAFullScale), 32'h1F);
    chk("start", startRampCycles, 32'(S0));
    rchk(8'h05, 8'h1F);
    rchk(8'h06, 8'h1F);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    wreg(8'h05, 8'hFF);
    rchk(8'h05, 8'hDF);
    wreg(8'h05, 8'h0A);
    chk("bankA", 32'(bankAFullScale), 32'h0A);
    wreg(8'h06, 8'hF3);
    rchk(8'h06, 8'h13);
    chk("bankB", 32'(bankBFullScale), 32'h13);
    rchk(8'h0C, 8'h00);
    // Every ramp code, start and shutdown running opposite ways
    for (int c = 0; c < 8; c++) begin
      wreg(8'h07, {2'b11, 3'(c), 3'(7 - c)});
      wreg(8'h08, {2'b11, 3'(7 - c), 3'(c)});
      chk("start", startRampCycles, rampExp(c, S0));
      chk("shut", shutRampCycles, rampExp(7 - c, Z0));
      chk("up", upRampCycles, rampExp(7 - c, Z0));
      chk("down", downRampCycles, rampExp(c, Z0));
    end
    rchk(8'h07, 8'h38);
    rchk(8'h08, 8'h07);
    // Each fault source, then the clearing read
    for (int i = 0; i < 3; i++) begin
      pulse(3'(1 << i));
      chk("pin", 32'(faultIrqPinNOe), 32'h1);
      rchk(8'h09, 8'(1 << i));
      chk("pin", 32'(faultIrqPinNOe), 32'h0);
      rchk(8'h09, 8'h00);
    end
    wreg(8'h09, 8'h07);
    rchk(8'h09, 8'h00);
    // Fault still present across the clearing read
    faults = 3'h1;
    repeat (10) @(negedge core_clk);
    rchk(8'h09, 8'h01);
    chk("pin", 32'(faultIrqPinNOe), 32'h1);
    faults = 3'h0;
    rchk(8'h09, 8'h01);
    rchk(8'h09, 8'h00);
    // Asleep: reads keep flags; host mutes the source meanwhile
    sleepStatus = 1'b1;
    pulse(3'h2);
    rchk(8'h09, 8'h02);
    rchk(8'h09, 8'h02);
    irqSourceEnable = 3'h5;
    repeat (3) @(negedge core_clk);
    chk("pin", 32'(faultIrqPinNOe), 32'h0);
    sleepStatus = 1'b0;
    rchk(8'h09, 8'h02);
    rchk(8'h09, 8'h00);
    // Global, then per-source enable gating
    irqSourceEnable = 3'h7;
    irqGlobalEnable = 1'b0;
    pulse(3'h4);
    chk("pin", 32'(faultIrqPinNOe), 32'h0);
    rchk(8'h09, 8'h00);
    irqGlobalEnable = 1'b1;
    irqSourceEnable = 3'h0;
    pulse(3'h4);
    rchk(8'h09, 8'h00);
    irqSourceEnable = 3'h7;
    // Sampler: slow then fast hysteresis, with and without the floor
    wreg(8'h05, 8'h4A);
    pwm(9'd100, 2, 9'd0);
    pwm(9'd100, 1, 9'd100);
    wreg(8'h05, 8'hCA);
    pwm(9'd3, 1, 9'd100);
    pwm(9'd3, 1, 9'd3);
    wreg(8'h05, 8'h8A);
    pwm(9'd4, 2, 9'd6);
    pwm(9'd1, 2, 9'd0);
    pwm(9'd2, 2, 9'd6);
    finishTest();
  end

  // Run needs about 62k cycles; a hang is cut well beyond that
  initial begin
    repeat (90000) @(posedge core_clk);
    badCount++;
    finishTest();
  end
endmodule : blr_regs_top_test
`default_nettype wire
